// ---- verilog/remote_ctrl_io_ports_clocking.sv ----
// remote control i/o ports, pull-downs, key-on wakeup, carrier pin and clock derivation
//
// What this block does
// - seven output-only bit-port pins, set or cleared singly or all cleared, open-drain high.
// - the digit pointer picks which bit-port bit set, reset or test acts on.
// - third pin of three-bit port is input only, pulled down, wakes on high.
// - nibble port pins are inputs when latch is 0; pulled down, wake on high.
// - after reset each pin floats until software writes 0 to its latch.
// - pull-down control bit 2 at 0 turns off the bit-port msb pull-down.
// - pull-down control bits 0 and 1 at 0 turn off the pull-downs of three-bit port pins 0 and 1.
// - system clock is oscillator over 8 until clock select, then undivided oscillator.
// - instruction clock is system clock divided by four, base timing of the core.
// - one instruction clock period is one machine cycle.
// - carrier leaves on a push-pull pin gated by the carrier control register.
`default_nettype none
module remote_ctrl_io_ports_clocking (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bit port pins, open-drain high side
  input wire logic [io_port_pkg::BIT_PORT_W-1:0] bit_port_io_pin_in,
  output logic [io_port_pkg::BIT_PORT_W-1:0] bit_port_io_pin_out,
  output logic [io_port_pkg::BIT_PORT_W-1:0] bit_port_io_pin_oe,
  // three-bit port pins; bit 2 is the input_only_pin
  input wire logic [io_port_pkg::E_IN_W-1:0] e_pin_in,
  output logic [io_port_pkg::E_OUT_W-1:0] e_pin_out,
  output logic [io_port_pkg::E_OUT_W-1:0] e_pin_oe,
  // nibble port pins
  input wire logic [io_port_pkg::G_W-1:0] g_pin_in,
  output logic [io_port_pkg::G_W-1:0] g_pin_out,
  output logic [io_port_pkg::G_W-1:0] g_pin_oe,
  // pull-down transistor enables: bit-port msb, three-bit port, nibble port
  output logic bit_port_msb_pulldown_en,
  output logic [io_port_pkg::E_IN_W-1:0] e_pulldown_en,
  output logic [io_port_pkg::G_W-1:0] g_pulldown_en,
  // carrier
  input wire logic carrier_src,
  output logic carrier_out,
  // core side
  input wire logic backup_mode,
  output logic wakeup_req,
  output logic system_clock,
  output logic instruction_clock,
  output logic irq
);
  import io_port_pkg::*;

  port_cmd_t cmd;
  logic wr_acc, rd_setup, cmd_wr;
  logic [BIT_PORT_W-1:0] bit_latch_q, bit_armed_q;
  logic [E_OUT_W-1:0] e_latch_q, e_armed_q;
  logic [G_W-1:0] g_latch_q, g_armed_q;
  logic [2:0] dptr_q;
  logic [PD_W-1:0] pd_q;
  logic [3:0] carrier_ctrl_q, result_q;
  logic clk_sel_q, skip_ev, wake_any;
  logic [STAT_W-1:0] stat_q, mask_q, ev;
  logic [2:0] sys_cnt_q;
  logic [1:0] inst_cnt_q;
  logic sys_tick, inst_tick;
  logic [15:0] mcycle_q;
  logic [BIT_PORT_W+E_IN_W+G_W-1:0] raw_in, s1_q, s2_q, s3_q, filt_q;
  logic msb_pin_in, carrier_q, wake_q;
  logic [E_IN_W-1:0] e_in;
  logic [G_W-1:0] g_in;
  logic [E_IN_W-1:0] e_wake_en;
  logic [G_W-1:0] g_wake_en;
  logic msb_wake_en;

  // decoding shared by write accept and error answer
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      OFS_CMD, OFS_DPTR, OFS_LATCH, OFS_PINS, OFS_PULLDN, OFS_STAT, OFS_MASK, OFS_CLK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr_acc = psel && penable && pwrite && addr_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign cmd_wr = wr_acc && (paddr == OFS_CMD);
  assign cmd = port_cmd_t'(pwdata[7:0]);

  // pin inputs: three stages, a change counts once stages two and three agree
  assign raw_in = {g_pin_in, e_pin_in, bit_port_io_pin_in};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < BIT_PORT_W + E_IN_W + G_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end
  assign msb_pin_in = filt_q[BIT_MSB];
  assign e_in = filt_q[BIT_PORT_W +: E_IN_W];
  assign g_in = filt_q[BIT_PORT_W+E_IN_W +: G_W];

  // digit pointer and pull-down control
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dptr_q <= '0;
      pd_q <= PD_RST;
    end else if (wr_acc && paddr == OFS_DPTR) begin
      dptr_q <= pwdata[2:0];
    end else if (wr_acc && paddr == OFS_PULLDN) begin
      pd_q <= pwdata[PD_W-1:0];
    end
  end

  // bit port latches; armed marks a latch that has once been written 0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_latch_q <= BIT_LATCH_RST;
      bit_armed_q <= '0;
    end else if (cmd_wr) begin
      case (cmd.opcode)
        OP_SET_BIT: bit_latch_q[dptr_q] <= 1'b1;
        OP_RESET_BIT: begin
          bit_latch_q[dptr_q] <= 1'b0;
          bit_armed_q[dptr_q] <= 1'b1;
        end
        OP_CLEAR_ALL: begin
          bit_latch_q <= '0;
          bit_armed_q <= '1;
        end
        default: bit_latch_q <= bit_latch_q;
      endcase
    end
  end

  // three-bit and nibble port latches, carrier control, clock select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      e_latch_q <= E_LATCH_RST;
      e_armed_q <= '0;
      g_latch_q <= G_LATCH_RST;
      g_armed_q <= '0;
      carrier_ctrl_q <= '0;
      clk_sel_q <= 1'b0;
    end else if (cmd_wr) begin
      case (cmd.opcode)
        OP_WRITE_THREE: begin
          e_latch_q <= cmd.data[E_OUT_W-1:0];
          e_armed_q <= e_armed_q | ~cmd.data[E_OUT_W-1:0];
        end
        OP_WRITE_NIBBLE: begin
          g_latch_q <= cmd.data;
          g_armed_q <= g_armed_q | ~cmd.data;
        end
        OP_WRITE_CARRIER: carrier_ctrl_q <= cmd.data;
        OP_CLOCK_SELECT: clk_sel_q <= 1'b1;
        default: clk_sel_q <= clk_sel_q;
      endcase
    end
  end

  // input reads and the zero test land in the result register
  assign skip_ev = cmd_wr && cmd.opcode == OP_SKIP_ZERO &&
                   ((dptr_q == 3'(BIT_MSB)) ? !msb_pin_in : !bit_latch_q[dptr_q]);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_q <= '0;
    end else if (cmd_wr && cmd.opcode == OP_READ_THREE) begin
      result_q <= {1'b0, e_in};
    end else if (cmd_wr && cmd.opcode == OP_READ_NIBBLE) begin
      result_q <= g_in;
    end else if (cmd_wr && cmd.opcode == OP_SKIP_ZERO) begin
      result_q <= {3'h0, skip_ev};
    end
  end

  // p-channel open drain: drives high only while armed and latch is 1
  generate
    for (genvar i = 0; i < BIT_PORT_W; i++) begin : g_bit
      assign bit_port_io_pin_out[i] = 1'b1;
      assign bit_port_io_pin_oe[i] = bit_armed_q[i] && bit_latch_q[i];
    end
    for (genvar i = 0; i < E_OUT_W; i++) begin : g_e
      assign e_pin_out[i] = 1'b1;
      assign e_pin_oe[i] = e_armed_q[i] && e_latch_q[i];
    end
    for (genvar i = 0; i < G_W; i++) begin : g_g
      assign g_pin_out[i] = 1'b1;
      assign g_pin_oe[i] = g_armed_q[i] && g_latch_q[i];
    end
  endgenerate

  // pull-downs
  assign bit_port_msb_pulldown_en = pd_q[PD_MSB];
  assign e_pulldown_en = {1'b1, pd_q[PD_E1], pd_q[PD_E0]};
  assign g_pulldown_en = '1;

  // key-on wakeup sources; a driven-high latch would wake itself, so it masks the pin
  assign msb_wake_en = pd_q[PD_MSB] && !bit_latch_q[BIT_MSB];
  assign e_wake_en = {1'b1, pd_q[PD_E1] && !e_latch_q[1], pd_q[PD_E0] && !e_latch_q[0]};
  assign g_wake_en = ~g_latch_q;
  assign wake_any = backup_mode && ((msb_wake_en && msb_pin_in) || |(e_wake_en & e_in) ||
                    |(g_wake_en & g_in));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_any;
    end
  end
  assign wakeup_req = wake_q;

  // carrier pin is push-pull: always driven, low while disabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      carrier_q <= 1'b0;
    end else begin
      carrier_q <= carrier_ctrl_q[0] && carrier_src;
    end
  end
  assign carrier_out = carrier_q;

  // system and instruction clock enables derived from the oscillator clock
  assign sys_tick = sys_cnt_q == (clk_sel_q ? SYS_DIV_FAST_M1 : SYS_DIV_SLOW_M1);
  assign inst_tick = sys_tick && inst_cnt_q == INST_DIV_M1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sys_cnt_q <= '0;
    end else if (sys_tick || clk_sel_q || (cmd_wr && cmd.opcode == OP_CLOCK_SELECT)) begin
      // cleared on the select itself so the first fast cycle already ticks
      sys_cnt_q <= '0;
    end else begin
      sys_cnt_q <= sys_cnt_q + 3'h1;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inst_cnt_q <= '0;
    end else if (sys_tick) begin
      inst_cnt_q <= inst_cnt_q + 2'h1;
    end
  end
  // machine cycles are counted one per instruction clock, wrapping
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mcycle_q <= '0;
    end else if (inst_tick) begin
      mcycle_q <= mcycle_q + 16'h1;
    end
  end
  assign system_clock = sys_tick;
  assign instruction_clock = inst_tick;

  // interrupt status: set wins over write-one-to-clear
  assign ev = {skip_ev, wake_any && !wake_q};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else if (wr_acc && paddr == OFS_STAT) begin
      stat_q <= (stat_q & ~pwdata[STAT_W-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (wr_acc && paddr == OFS_MASK) begin
      mask_q <= pwdata[STAT_W-1:0];
    end
  end
  assign irq = |(stat_q & mask_q);

  // read data registered in the setup cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        OFS_DPTR: prdata <= {29'h0, dptr_q};
        OFS_LATCH: prdata <= {14'h0, carrier_ctrl_q, g_latch_q, e_latch_q, bit_latch_q};
        OFS_PINS: prdata <= {20'h0, result_q, g_in, e_in, msb_pin_in};
        OFS_PULLDN: prdata <= {29'h0, pd_q};
        OFS_STAT: prdata <= {30'h0, stat_q};
        OFS_MASK: prdata <= {30'h0, mask_q};
        OFS_CLK: prdata <= {15'h0, mcycle_q, clk_sel_q};
        default: prdata <= '0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // a write of 0 into the bit port, the only way a latch gets armed
  logic zero_wr_cmd;
  assign zero_wr_cmd = cmd_wr && (cmd.opcode == OP_CLEAR_ALL || cmd.opcode == OP_RESET_BIT);

  sequence s_cmd(port_op_t op);
    cmd_wr && cmd.opcode == op;
  endsequence
  sequence s_slow_period;
    (!sys_tick || clk_sel_q) [*7] ##1 (sys_tick || clk_sel_q);
  endsequence
  sequence s_inst_period;
    !inst_tick [*3] ##1 inst_tick;
  endsequence

  a_clear_all_latch: assert property (s_cmd(OP_CLEAR_ALL) |=> bit_latch_q == '0 && bit_port_io_pin_oe == '0)
    else $error("clear all left a bit port latch set");
  a_set_bit_pointer: assert property (s_cmd(OP_SET_BIT) |=> bit_latch_q[$past(dptr_q)] == 1'b1)
    else $error("set did not reach the pointed bit");
  a_hiz_until_armed: assert property (!bit_armed_q[BIT_MSB] && !zero_wr_cmd |=> !bit_port_io_pin_oe[BIT_MSB])
    else $error("pin driven before its latch was written 0");
  a_msb_pulldown_off: assert property (wr_acc && paddr == OFS_PULLDN && !pwdata[PD_MSB]
                                       |=> !bit_port_msb_pulldown_en)
    else $error("msb pull-down still on after writing 0");
  a_e_pulldown_off: assert property (wr_acc && paddr == OFS_PULLDN && pwdata[PD_E1:PD_E0] == 2'h0
                                     |=> e_pulldown_en == 3'h4)
    else $error("three-bit pull-downs still on");
  a_sys_div_slow: assert property (sys_tick && !clk_sel_q && !cmd_wr |=> s_slow_period)
    else $error("slow system clock not every 8 cycles");
  a_sys_div_fast: assert property (clk_sel_q |-> sys_tick)
    else $error("selected system clock not undivided");
  a_inst_div_four: assert property (inst_tick && clk_sel_q |=> s_inst_period)
    else $error("instruction clock not system clock over four");
  a_machine_cycle: assert property (inst_tick |=> mcycle_q == $past(mcycle_q) + 16'h1)
    else $error("machine cycle not counted per instruction clock");
  a_carrier_gate: assert property (!carrier_ctrl_q[0] |=> !carrier_out)
    else $error("carrier driven while disabled");
  a_wake_input_only: assert property (backup_mode && e_in[2] |=> wakeup_req)
    else $error("input-only pin high gave no wakeup");
  a_nibble_input: assert property (cmd_wr && cmd.opcode == OP_WRITE_NIBBLE && !cmd.data[0]
                                   |=> !g_pin_oe[0] && !g_latch_q[0])
    else $error("nibble pin driven while used as input");

endmodule
`default_nettype wire

// ---- verilog/io_port_pkg.sv ----
// constants and types shared by the remote control port and clock block
`default_nettype none
package io_port_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DPTR = 8'h04;
  localparam logic [7:0] OFS_LATCH = 8'h08;
  localparam logic [7:0] OFS_PINS = 8'h0c;
  localparam logic [7:0] OFS_PULLDN = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_CLK = 8'h1c;

  // widths of the ports, the pull-down control and the status register
  localparam int BIT_PORT_W = 8;
  localparam int E_OUT_W = 2;
  localparam int E_IN_W = 3;
  localparam int G_W = 4;
  localparam int PD_W = 3;
  localparam int STAT_W = 2;

  // pull-down control bit positions and the bit-port msb index
  localparam int PD_E0 = 0;
  localparam int PD_E1 = 1;
  localparam int PD_MSB = 2;
  localparam int BIT_MSB = 7;

  // status bit positions
  localparam int ST_WAKE = 0;
  localparam int ST_SKIP = 1;

  // reset values
  localparam logic [BIT_PORT_W-1:0] BIT_LATCH_RST = 8'hff;
  localparam logic [E_OUT_W-1:0] E_LATCH_RST = 2'h3;
  localparam logic [G_W-1:0] G_LATCH_RST = 4'hf;
  localparam logic [PD_W-1:0] PD_RST = 3'h0;

  // clock division
  localparam logic [2:0] SYS_DIV_SLOW_M1 = 3'h7;
  localparam logic [2:0] SYS_DIV_FAST_M1 = 3'h0;
  localparam logic [1:0] INST_DIV_M1 = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_SET_BIT = 4'h1,
    OP_RESET_BIT = 4'h2,
    OP_CLEAR_ALL = 4'h3,
    OP_SKIP_ZERO = 4'h4,
    OP_WRITE_THREE = 4'h5,
    OP_READ_THREE = 4'h6,
    OP_WRITE_NIBBLE = 4'h7,
    OP_READ_NIBBLE = 4'h8,
    OP_WRITE_CARRIER = 4'h9,
    OP_CLOCK_SELECT = 4'ha
  } port_op_t;

  // command word as written to the command register
  typedef struct packed {
    logic [3:0] data;
    logic [3:0] opcode;
  } port_cmd_t;

endpackage
`default_nettype wire

// ---- verification/key_matrix_model.sv ----
// key matrix and pin load model for the port block
`default_nettype none
module key_matrix_model (
  // clock and pin drive from the block
  input wire logic clock,
  input wire logic [7:0] d_oe,
  input wire logic d_pd,
  input wire logic [1:0] e_oe,
  input wire logic [2:0] e_pd,
  input wire logic [3:0] g_oe,
  input wire logic [3:0] g_pd,
  // keys held by the bench: d 0..7, e 8..10, g 11..14
  input wire logic [14:0] keys,
  // levels back into the block
  output logic [7:0] d_in,
  output logic [2:0] e_in,
  output logic [3:0] g_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] pd;
  logic [14:0] oe;
  logic [14:0] lvl;
  logic flip = 1'b0;
  // an undriven pin with no pull-down wanders, so it never settles here
  always @(posedge clock) flip <= ~flip;
  assign pd = {g_pd, e_pd, d_pd, 7'h00};
  assign oe = {g_oe, 1'b0, e_oe, d_oe};
  // pressed key or p-channel drive pulls high, else the pull-down holds low
  always_comb begin
    for (int i = 0; i < 15; i++) lvl[i] = (oe[i] | keys[i]) ? 1'b1 : (pd[i] ? 1'b0 : flip);
  end
  assign {g_in, e_in, d_in} = lvl;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the remote control port and clock block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import io_port_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic carrier_src = 1'b0;
  logic backup_mode = 1'b0;
  logic [14:0] keys = 15'h0;
  logic [31:0] prdata;
  logic pready, pslverr, last_err, d_pd, carrier_out, wakeup_req, system_clock, instruction_clock, irq;
  logic [7:0] d_in, d_out, d_oe;
  logic [2:0] e_in, e_pd;
  logic [1:0] e_out, e_oe;
  logic [3:0] g_in, g_out, g_oe, g_pd, r;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] exp_q[$];

  always #5 clock = ~clock;

  remote_ctrl_io_ports_clocking dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_port_io_pin_in(d_in), .bit_port_io_pin_out(d_out), .bit_port_io_pin_oe(d_oe),
    .e_pin_in(e_in), .e_pin_out(e_out), .e_pin_oe(e_oe), .g_pin_in(g_in), .g_pin_out(g_out),
    .g_pin_oe(g_oe), .bit_port_msb_pulldown_en(d_pd), .e_pulldown_en(e_pd), .g_pulldown_en(g_pd),
    .carrier_src(carrier_src), .carrier_out(carrier_out), .backup_mode(backup_mode),
    .wakeup_req(wakeup_req), .system_clock(system_clock), .instruction_clock(instruction_clock),
    .irq(irq)
  );

  key_matrix_model partner (
    .clock(clock), .d_oe(d_oe), .d_pd(d_pd), .e_oe(e_oe), .e_pd(e_pd), .g_oe(g_oe),
    .g_pd(g_pd), .keys(keys), .d_in(d_in), .e_in(e_in), .g_in(g_in)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer; the trailing edge keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // only the hang guard ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input port_op_t op, input logic [3:0] dat);
    apb(1'b1, OFS_CMD, {24'h0, port_cmd_t'{data: dat, opcode: op}});
  endtask

  task automatic count_clk(input int n, input int sys_e, input int ins_e);
    int s;
    int k;
    s = 0;
    k = 0;
    repeat (n) begin
      @(posedge clock);
      s += int'(system_clock);
      k += int'(instruction_clock);
    end
    check("system clock pulses", s, sys_e);
    check("instruction clock pulses", k, ins_e);
  endtask

  // read data is compared against the oldest noted expectation
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) check("read data", prdata, exp_q.pop_front());
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    int k;
    int n;
    void'($urandom(67291));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("pin enables", {d_oe, e_oe, g_oe}, 32'h0);
    check("pin levels", {d_out, e_out, g_out}, 32'h3fff);
    check("pull-downs", {d_pd, e_pd, g_pd}, 32'h4f);
    cmd(OP_NOP, 4'h0);
    rd(OFS_LATCH, 32'h3fff);
    rd(OFS_PULLDN, 32'h0);
    count_clk(64, 8, 2);
    $display("test reset and slow clock done");
    cmd(OP_CLEAR_ALL, 4'h0);
    rd(OFS_LATCH, 32'h3f00);
    k = $urandom_range(6);
    apb(1'b1, OFS_DPTR, k);
    cmd(OP_SET_BIT, 4'h0);
    @(posedge clock);
    check("bit port enable", d_oe, 32'h1 << k);
    cmd(OP_RESET_BIT, 4'h0);
    rd(OFS_LATCH, 32'h3f00);
    $display("test bit port done");
    apb(1'b1, OFS_PULLDN, 32'h7);
    cmd(OP_WRITE_THREE, 4'h0);
    cmd(OP_WRITE_NIBBLE, 4'h0);
    check("pull-downs", {d_pd, e_pd, g_pd}, 32'hff);
    backup_mode <= 1'b1;
    k = 7 + $urandom_range(7);
    keys[k] <= 1'b1;
    n = 0;
    while (wakeup_req !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    check("wakeup", wakeup_req, 32'h1);
    apb(1'b1, OFS_MASK, 32'h1);
    check("irq", irq, 32'h1);
    rd(OFS_STAT, 32'h1);
    keys <= 15'h0;
    backup_mode <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1'b1, OFS_STAT, 32'h3);
    rd(OFS_STAT, 32'h0);
    check("irq", irq, 32'h0);
    $display("test wakeup done");
    apb(1'b1, OFS_DPTR, 32'h3);
    cmd(OP_SET_BIT, 4'h0);
    cmd(OP_SKIP_ZERO, 4'h0);
    rd(OFS_STAT, 32'h0);
    apb(1'b1, OFS_DPTR, 32'h7);
    cmd(OP_SKIP_ZERO, 4'h0);
    rd(OFS_STAT, 32'h2);
    r = 4'($urandom_range(15));
    keys[14:10] <= {r, 1'b1};
    backup_mode <= 1'b1;
    repeat (8) @(posedge clock);
    check("input-only wakeup", wakeup_req, 32'h1);
    cmd(OP_READ_NIBBLE, 4'h0);
    rd(OFS_PINS, {20'h0, r, r, 4'h8});
    cmd(OP_READ_THREE, 4'h0);
    rd(OFS_PINS, {20'h0, 4'h4, r, 4'h8});
    keys <= 15'h0;
    backup_mode <= 1'b0;
    $display("test inputs done");
    for (int c = 0; c < 2; c++) begin
      cmd(OP_WRITE_CARRIER, 4'(c));
      repeat (4) begin
        k = $urandom_range(1);
        carrier_src <= k[0];
        repeat (2) @(posedge clock);
        check("carrier", carrier_out, k[0] & c[0]);
      end
    end
    $display("test carrier done");
    rd(8'h20, 32'h0);
    check("slave error", last_err, 32'h1);
    rd(OFS_PULLDN, 32'h7);
    check("slave error", last_err, 32'h0);
    apb(1'b1, OFS_PULLDN, 32'h0);
    check("pull-downs off", {d_pd, e_pd, g_pd}, 32'h4f);
    cmd(OP_CLOCK_SELECT, 4'h0);
    count_clk(64, 64, 16);
    $display("test fast clock done");
    results();
  end
endmodule
`default_nettype wire
